/* dv/pds_dev_model.sv */
/*
  Behavioural model of the pre-driver: serial port, interrupt pin, lock and input order.
  Assumes the host sends MSB first and the device samples on the rising link clock.
*/
`timescale 1ns/10ps
module pds_dev_model (
  input wire logic rst_n_i, // device reset, low active
  input wire logic en_i, // both enables high
  input wire logic [2:0] ls_i, // low sides, high = on
  input wire logic [2:0] hs_n_i, // high sides, low = on
  input wire logic sclk_i, // link clock
  input wire logic cs_n_i, // link select
  input wire logic mosi_i, // host data
  input wire logic fault_i, // bench fault event
  output logic miso_o, // answer bit
  output logic irq_o // interrupt pin
);
  import pds_pkg::*;
  logic [7:0] sh_in, sh_out, ans, mode_reg;
  logic [3:0] mask;
  logic locked, armed, bad, framed;
  logic [7:0] cmd_log [0:15];
  int n_cmd;
  initial begin
    {miso_o, irq_o, locked, armed, bad, framed, mode_reg, mask, ans, sh_in} = '0;
    n_cmd = 0;
  end
  // reset drops the lock and any latched fault
  always @(negedge rst_n_i) {irq_o, locked, armed} = '0;
  always @(posedge fault_i) irq_o = 1'b1;
  // the previous frame's answer goes out, never the current one
  always @(negedge cs_n_i) begin
    framed = 1'b1;
    sh_out = ans;
    miso_o = sh_out[7];
  end
  always @(posedge sclk_i) if (!cs_n_i) sh_in = {sh_in[6:0], mosi_i};
  always @(negedge sclk_i) if (!cs_n_i) begin
    sh_out = {sh_out[6:0], 1'b0};
    miso_o = sh_out[7];
  end
  // released line shows the inverse, so a stale bit cannot pass for data
  // only a release that closes a frame counts; the select settling at power-up is no frame
  always @(posedge cs_n_i) if (framed) begin
    framed = 1'b0;
    miso_o = ~miso_o;
    if (n_cmd < 16) cmd_log[n_cmd] = sh_in;
    n_cmd++;
    ans = sh_in ^ 8'h5A;
    if (sh_in[7:5] == 3'h1) mask = sh_in[3:0];
    if (sh_in == CMD_CLR0 || sh_in == CMD_CLR1) irq_o = 1'b0;
    if (sh_in[7:5] == 3'h2 && !locked) begin
      mode_reg = sh_in;
      locked = sh_in[LOCK_BIT];
    end
  end
  // phase A stands for all three: the host drives them as one
  // the pin settling low at power-up is no toggle, so arm only on a fall while enabled
  always @(negedge ls_i[0]) if (en_i) armed = 1'b1;
  always @(posedge ls_i[0]) if (!en_i) bad = 1'b1;
  always @(negedge hs_n_i[0]) if (!armed) bad = 1'b1;
endmodule

/* dv/tb.sv */
/*
  Self-checking bench for the sequencer: bus tasks, one task per scenario.
  Assumes the device model above stands on the far side of the pins.
*/
`timescale 1ns/10ps
module tb;
  import pds_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fault = 0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, d;
  logic ack, irq, dev_rst_n, en_a, en_b, sclk, cs_n, mosi, miso, dev_irq, p_rst, p_en, p_cs;
  logic [2:0] hs_n, ls, p_ls, p_hs;
  int n_fail = 0, num_checks = 0, cyc_n = 0, t_rst, t_en, t_lsu, t_lsd, t_hsd, t_hsu, t_cs;
  logic [7:0] i_exp [0:4] = '{CMD_CLR0, CMD_CLR1, 8'h35, 8'h80, 8'h41};
  logic [7:0] q_exp [0:4] = '{CMD_STATUS_QUERY0_CMD, CMD_STATUS_QUERY1_CMD, CMD_STATUS_QUERY0_CMD, CMD_CLR0, CMD_CLR1};
  initial forever #12.5 clk_i = ~clk_i;
  pds_sequencer pds_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .dev_rst_n_o(dev_rst_n), .output_enable_a_o(en_a), .output_enable_b_o(en_b),
    .high_side_ctrl_n_o(hs_n), .low_side_ctrl_o(ls), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
    .spi_mosi_o(mosi), .spi_miso_i(miso), .dev_irq_i(dev_irq));
  pds_dev_model pds_dev_model_inst (.rst_n_i(dev_rst_n), .en_i(en_a & en_b), .ls_i(ls), .hs_n_i(hs_n),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .fault_i(fault), .miso_o(miso), .irq_o(dev_irq));
  // pin edge time stamps; a hang past the ceiling ends the run
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    {p_rst, p_en, p_cs, p_ls, p_hs} <= {dev_rst_n, en_a, cs_n, ls, hs_n};
    if (dev_rst_n && !p_rst) t_rst <= cyc_n;
    if (en_a && !p_en) t_en <= cyc_n;
    if (cs_n && !p_cs) t_cs <= cyc_n;
    if (ls[0] && !p_ls[0]) t_lsu <= cyc_n;
    if (!ls[0] && p_ls[0]) t_lsd <= cyc_n;
    if (!hs_n[0] && p_hs[0]) t_hsd <= cyc_n;
    if (hs_n[0] && !p_hs[0]) t_hsu <= cyc_n;
    if (cyc_n == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // classic single cycle: hold everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] r);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, dv};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 400; i++) begin
      wb(1'b0, ADR_STAT, '0, d);
      if ((d & m) === v) break;
    end
  endtask
  // frames are counted by the model; then wait for idle and ready
  task automatic wait_cmds(input int n);
    for (int i = 0; i < 4000 && pds_dev_model_inst.n_cmd < n; i++) @(posedge clk_i);
    poll(32'h3, 32'h2);
  endtask
  task automatic check_q(input int b);
    for (int i = 0; i < 5; i++) check("query cmd", q_exp[i], pds_dev_model_inst.cmd_log[b + i]);
    wb(1'b0, ADR_RESP, '0, d);
    check("resp", {CMD_STATUS_QUERY1_CMD ^ 8'h5A, CMD_STATUS_QUERY0_CMD ^ 8'h5A}, d);
  endtask
  task automatic t_reset();
    check("dev_rst_n", '0, dev_rst_n);
    check("enables", '0, {en_a, en_b});
    check("hs_n", 32'h7, hs_n);
    check("ls", '0, ls);
    wb(1'b0, ADR_CFG, '0, d);
    check("cfg", CFG_RST, d);
    wb(1'b0, ADR_MASK, '0, d);
    check("mask reg", MASK_RST, d);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, d);
    wb(1'b0, 8'h20, '0, d);
    check("unmapped", '0, d);
    $display("test reset done");
  endtask
  task automatic t_init();
    wb(1'b1, ADR_CFG, 32'h0080_4015, d);
    wb(1'b1, ADR_MASK, 32'h1, d);
    wb(1'b1, ADR_CTRL, 32'h1, d);
    poll(32'h2, 32'h2);
    for (int i = 0; i < 5; i++) check("init cmd", i_exp[i], pds_dev_model_inst.cmd_log[i]);
    check("cmd count", 32'h5, pds_dev_model_inst.n_cmd);
    check("locked", 32'h1, pds_dev_model_inst.locked);
    check("dev mask", 32'h5, pds_dev_model_inst.mask);
    check("rst before en", 32'h1, t_rst < t_en);
    check("frames before en", 32'h1, t_cs < t_en);
    check("en to ls", 32'h1, (t_lsu - t_en) * CLK_NS >= EN_LS_NS);
    check("ls on", 32'h1, (t_lsd - t_lsu) * CLK_NS >= LS_ON_NS);
    check("ls off first", 32'h1, t_hsd > t_lsd);
    check("hs pulse", 32'h1, (t_hsu - t_hsd) * CLK_NS >= DEAD_NS + HS_EXTRA_NS);
    check("pins end", 32'h38, {hs_n, ls});
    check("order", 32'h1, {pds_dev_model_inst.bad, pds_dev_model_inst.armed});
    check("irq done", 32'h1, irq);
    wb(1'b0, ADR_IRQ, '0, d);
    check("irq stat", 32'h1, d);
    @(posedge clk_i);
    check("irq cleared", '0, irq);
    $display("test init done");
  endtask
  task automatic t_service();
    wb(1'b1, ADR_MASK, 32'h6, d);
    @(posedge clk_i);
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    wait_cmds(10);
    check_q(5);
    check("dev irq", '0, dev_irq);
    check("irq fault", 32'h1, irq);
    wb(1'b0, ADR_IRQ, '0, d);
    check("irq stat", 32'h6, d);
    @(posedge clk_i);
    check("irq cleared", '0, irq);
    $display("test service done");
  endtask
  // a query with its event masked must stay quiet until unmasked
  task automatic t_query();
    wb(1'b1, ADR_MASK, '0, d);
    wb(1'b1, ADR_CTRL, 32'h2, d);
    wait_cmds(15);
    check_q(10);
    check("irq masked", '0, irq);
    wb(1'b1, ADR_MASK, 32'h4, d);
    @(posedge clk_i);
    check("irq unmasked", 32'h1, irq);
    wb(1'b0, ADR_IRQ, '0, d);
    check("irq stat", 32'h4, d);
    $display("test query done");
  endtask
  // a restart from ready re-runs everything with enables low; the device keeps its locked mode
  task automatic t_restart();
    wb(1'b1, ADR_CFG, 32'h0080_4203, d);
    wb(1'b1, ADR_CTRL, 32'h1, d);
    wait_cmds(20);
    check("dev mask grp0", 32'h3, pds_dev_model_inst.mask);
    check("mode kept", 32'h41, pds_dev_model_inst.mode_reg);
    check("frames before en", 32'h1, t_cs < t_en);
    check("pins end", 32'h38, {hs_n, ls});
    check("order", 32'h1, {pds_dev_model_inst.bad, pds_dev_model_inst.armed});
    wb(1'b0, ADR_IRQ, '0, d);
    check("irq stat", 32'h1, d);
    $display("test restart done");
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_init();
    t_service();
    t_query();
    t_restart();
    results();
  end
endmodule

/* rtl/pds_pkg.sv */
/*
  Constants, register map and state type for the pre-driver start-up sequencer.
  Assumes a 40 MHz system clock; every timing count below except SPI_HALF is derived from it.
*/
// Behaviour
// - release device reset, enables low, then configure
// - first send both clear-interrupt commands
// - mask command upper nibble 0010 or 0011
// - set dead time before enabling outputs
// - mode command always carries lock bit
// - raise both enables before output initialisation
// - high sides held off at start
// - low sides rise only after enables high
// - low sides on about one microsecond
// - then all low sides off
// - pulse high sides on, then off
// - on interrupt query status, then clear fault
// - status reads not split by interrupt service
// - wait 280 ns from enables to low side
// - high-side pulse at least dead time plus 100 ns
package pds_pkg;
  localparam int CLK_NS = 25;
  localparam int BOOT_NS = 1000;
  localparam int EN_LS_NS = 280;
  localparam int LS_ON_NS = 1000;
  localparam int DEAD_NS = 1000;
  localparam int HS_EXTRA_NS = 100;
  localparam logic [11:0] BOOT_CYC = 12'((BOOT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] EN_LS_CYC = 12'((EN_LS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] LS_ON_CYC = 12'((LS_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] HS_ON_CYC = 12'((DEAD_NS + HS_EXTRA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] SPI_HALF = 2'h1;
  // command codes not given elsewhere; plain defaults
  localparam logic [7:0] CMD_CLR0 = 8'h6F;
  localparam logic [7:0] CMD_CLR1 = 8'h7F;
  localparam logic [7:0] CMD_STATUS_QUERY0_CMD = 8'h00;
  localparam logic [7:0] CMD_STATUS_QUERY1_CMD = 8'h01;
  localparam logic [3:0] MASK_HI0 = 4'h2;
  localparam logic [3:0] MASK_HI1 = 4'h3;
  localparam int LOCK_BIT = 0;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CFG = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_RESP = 8'h0C;
  localparam logic [7:0] ADR_IRQ = 8'h10;
  localparam logic [7:0] ADR_MASK = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_QUERY = 1;
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_MGRP = 4;
  localparam int CFG_MODE_LSB = 8;
  localparam int CFG_DT_LSB = 16;
  localparam logic [31:0] CFG_RST = 32'h0080_4000;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_RESP = 2;
  // command sequence steps
  localparam logic [3:0] STEP_CLR0 = 4'h0;
  localparam logic [3:0] STEP_CLR1 = 4'h1;
  localparam logic [3:0] STEP_MASK = 4'h2;
  localparam logic [3:0] STEP_DEAD = 4'h3;
  localparam logic [3:0] STEP_MODE = 4'h4;
  localparam logic [3:0] STEP_Q0 = 4'h5;
  localparam logic [3:0] STEP_Q1 = 4'h6;
  localparam logic [3:0] STEP_QD = 4'h7;
  localparam logic [3:0] STEP_FC0 = 4'h8;
  localparam logic [3:0] STEP_FC1 = 4'h9;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_BOOT = 4'h1,
    ST_SEND = 4'h3,
    ST_XFER = 4'h2,
    ST_ENWAIT = 4'h6,
    ST_LSON = 4'h7,
    ST_LSOFF = 4'h5,
    ST_HSON = 4'h4,
    ST_READY = 4'hC
  } pds_state_type;
endpackage

/* rtl/pds_sequencer.sv */
/*
  Host-side sequencer for a three-phase gate pre-driver: reset release,
  register set-up over the serial link, output initialisation and
  interrupt service, ordered by software over a classic Wishbone slave.
  Assumes the device interrupt pin is asynchronous and active high.
*/
`timescale 1ns/10ps
module pds_sequencer (
  input wire logic clk_i, // system clock, 40 MHz
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic irq_o, // interrupt to software
  output logic dev_rst_n_o, // device reset, low active
  output logic output_enable_a_o, // device enable one
  output logic output_enable_b_o, // device enable two
  output logic [2:0] high_side_ctrl_n_o, // high sides, low = on
  output logic [2:0] low_side_ctrl_o, // low sides, high = on
  output logic spi_sclk_o, // link clock
  output logic spi_cs_n_o, // link select, low active
  output logic spi_mosi_o, // link data out
  input wire logic spi_miso_i, // link data in
  input wire logic dev_irq_i // device interrupt pin
);
  import pds_pkg::*;

  pds_state_type state_reg;
  logic [3:0] step_reg;
  logic [31:0] cfg_reg;
  logic [2:0] mask_reg;
  logic [2:0] irq_reg;
  logic [2:0] irq_set;
  logic [7:0] resp0_reg;
  logic [7:0] resp1_reg;
  logic resp_ok_reg;
  logic rst_n_reg;
  logic en_reg;
  logic [2:0] hs_reg;
  logic [2:0] ls_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [1:0] dirq_sync_reg;
  logic dirq;
  logic wb_hit;
  logic wr_ctrl;
  logic start_req;
  logic query_req;
  logic tmr_load;
  logic [11:0] tmr_cnt;
  logic tmr_done;
  logic spi_start;
  logic [7:0] spi_cmd;
  logic spi_done;
  logic [7:0] spi_rx;
  logic spi_busy;

  // byte-lane merge for writable registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // command byte for each step of the fixed sequence
  function automatic logic [7:0] step_cmd(input logic [3:0] step, input logic [31:0] cfg);
    logic [7:0] c;
    c = CMD_STATUS_QUERY0_CMD;
    unique case (step)
      STEP_CLR0, STEP_FC0: c = CMD_CLR0;
      STEP_CLR1, STEP_FC1: c = CMD_CLR1;
      STEP_MASK: c = {cfg[CFG_MGRP] ? MASK_HI1 : MASK_HI0, cfg[CFG_MASK_LSB +: 4]};
      STEP_DEAD: c = cfg[CFG_DT_LSB +: 8];
      STEP_MODE: c = cfg[CFG_MODE_LSB +: 8] | 8'(1 << LOCK_BIT);
      STEP_Q0, STEP_QD: c = CMD_STATUS_QUERY0_CMD;
      STEP_Q1: c = CMD_STATUS_QUERY1_CMD;
      default: c = CMD_STATUS_QUERY0_CMD;
    endcase
    return c;
  endfunction

  // device interrupt pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dirq_sync_reg <= 2'h0;
    end else begin
      dirq_sync_reg <= {dirq_sync_reg[0], dev_irq_i};
    end
  end
  assign dirq = dirq_sync_reg[1];

  // bus decode: one wait state, every address answered
  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_ctrl = wb_hit && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[0];
  assign start_req = wr_ctrl && wb_dat_i[CTRL_START];
  assign query_req = wr_ctrl && wb_dat_i[CTRL_QUERY];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_hit;
    end
  end

  // configuration and mask, byte-lane writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= CFG_RST;
      mask_reg <= MASK_RST;
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == ADR_CFG) begin
        cfg_reg <= lane_merge(cfg_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == ADR_MASK && wb_sel_i[0]) begin
        mask_reg <= wb_dat_i[2:0];
      end
    end
  end

  // read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CFG: dat_reg <= cfg_reg;
        ADR_STAT: dat_reg <= {24'h00_0000, state_reg, resp_ok_reg, dirq, state_reg == ST_READY,
                              state_reg != ST_IDLE && state_reg != ST_READY};
        ADR_RESP: dat_reg <= {16'h0000, resp1_reg, resp0_reg};
        ADR_IRQ: dat_reg <= {29'h0000_0000, irq_reg};
        ADR_MASK: dat_reg <= {29'h0000_0000, mask_reg};
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;

  // sticky events; reading clears, a new event in that cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 3'h0;
    end else if (wb_hit && !wb_we_i && wb_adr_i == ADR_IRQ) begin
      irq_reg <= irq_set;
    end else begin
      irq_reg <= irq_reg | irq_set;
    end
  end
  assign irq_o = |(irq_reg & mask_reg);

  // event sources decoded from the sequencer's progress
  always_comb begin
    irq_set = 3'h0;
    irq_set[IRQ_DONE] = (state_reg == ST_HSON) && tmr_done;
    irq_set[IRQ_FAULT] = (state_reg == ST_READY) && dirq;
    irq_set[IRQ_RESP] = (state_reg == ST_XFER) && spi_done && (step_reg == STEP_FC1);
  end

  assign spi_start = (state_reg == ST_SEND);
  assign spi_cmd = step_cmd(step_reg, cfg_reg);

  // timer loads come from the state that begins each wait
  always_comb begin
    tmr_load = 1'b0;
    tmr_cnt = 12'h000;
    if (start_req && (state_reg == ST_IDLE || state_reg == ST_READY)) begin
      tmr_load = 1'b1;
      tmr_cnt = BOOT_CYC;
    end else if (state_reg == ST_XFER && spi_done && step_reg == STEP_MODE) begin
      tmr_load = 1'b1;
      tmr_cnt = EN_LS_CYC;
    end else if (state_reg == ST_ENWAIT && tmr_done) begin
      tmr_load = 1'b1;
      tmr_cnt = LS_ON_CYC;
    end else if (state_reg == ST_LSOFF) begin
      tmr_load = 1'b1;
      tmr_cnt = HS_ON_CYC;
    end
  end

  // main sequence; interrupt service runs only from ready, never mid-init
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      step_reg <= STEP_CLR0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_READY: begin
          if (start_req) begin
            state_reg <= ST_BOOT;
          end else if (state_reg == ST_READY && (dirq || query_req)) begin
            step_reg <= STEP_Q0;
            state_reg <= ST_SEND;
          end
        end
        ST_BOOT: begin
          if (tmr_done) begin
            step_reg <= STEP_CLR0;
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: state_reg <= ST_XFER;
        ST_XFER: begin
          if (spi_done) begin
            if (step_reg == STEP_MODE) begin
              state_reg <= ST_ENWAIT;
            end else if (step_reg == STEP_FC1) begin
              state_reg <= ST_READY;
            end else begin
              step_reg <= step_reg + 4'h1;
              state_reg <= ST_SEND;
            end
          end
        end
        ST_ENWAIT: if (tmr_done) state_reg <= ST_LSON;
        ST_LSON: if (tmr_done) state_reg <= ST_LSOFF;
        ST_LSOFF: state_reg <= ST_HSON;
        ST_HSON: if (tmr_done) state_reg <= ST_READY;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // device pins follow the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_n_reg <= 1'b0;
      en_reg <= 1'b0;
      hs_reg <= 3'h7;
      ls_reg <= 3'h0;
    end else begin
      if (start_req && (state_reg == ST_IDLE || state_reg == ST_READY)) begin
        rst_n_reg <= 1'b1;
        en_reg <= 1'b0;
        hs_reg <= 3'h7;
        ls_reg <= 3'h0;
      end else if (state_reg == ST_XFER && spi_done && step_reg == STEP_MODE) begin
        en_reg <= 1'b1;
        hs_reg <= 3'h7;
      end else if (state_reg == ST_ENWAIT && tmr_done) begin
        ls_reg <= 3'h7;
      end else if (state_reg == ST_LSON && tmr_done) begin
        ls_reg <= 3'h0;
      end else if (state_reg == ST_LSOFF) begin
        hs_reg <= 3'h0;
      end else if (state_reg == ST_HSON && tmr_done) begin
        hs_reg <= 3'h7;
      end
    end
  end
  assign dev_rst_n_o = rst_n_reg;
  assign output_enable_a_o = en_reg;
  assign output_enable_b_o = en_reg;
  assign high_side_ctrl_n_o = hs_reg;
  assign low_side_ctrl_o = ls_reg;

  // each answer belongs to the previous frame; whole query is atomic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp0_reg <= 8'h00;
      resp1_reg <= 8'h00;
      resp_ok_reg <= 1'b0;
    end else if (state_reg == ST_XFER && spi_done) begin
      if (step_reg == STEP_Q0) begin
        resp_ok_reg <= 1'b0;
      end
      if (step_reg == STEP_Q1) begin
        resp0_reg <= spi_rx;
      end
      if (step_reg == STEP_QD) begin
        resp1_reg <= spi_rx;
        resp_ok_reg <= 1'b1;
      end
    end
  end

  pds_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .cnt_i(tmr_cnt),
    .done_o(tmr_done)
  );

  pds_spi u_spi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(spi_start),
    .data_i(spi_cmd),
    .busy_o(spi_busy),
    .done_o(spi_done),
    .rx_o(spi_rx),
    .sclk_o(spi_sclk_o),
    .cs_n_o(spi_cs_n_o),
    .mosi_o(spi_mosi_o),
    .miso_i(spi_miso_i)
  );

  // helper counters, read only by the checks below
  logic [11:0] en_cnt;
  logic [11:0] ls_cnt;
  logic [11:0] hs_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_cnt <= 12'h000;
      ls_cnt <= 12'h000;
      hs_cnt <= 12'h000;
    end else begin
      en_cnt <= !en_reg ? 12'h000 : (en_cnt == 12'hFFF ? en_cnt : en_cnt + 12'h001);
      ls_cnt <= state_reg == ST_ENWAIT ? 12'h000 : (ls_reg[0] ? ls_cnt + 12'h001 : ls_cnt);
      hs_cnt <= hs_reg[0] ? 12'h000 : hs_cnt + 12'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cfg_enables_low: assert property (spi_start && step_reg <= STEP_MODE |-> !en_reg && rst_n_reg)
    else $error("enables high or reset held during register set-up");
  a_clear_pair: assert property (spi_done && state_reg == ST_XFER && step_reg == STEP_CLR0
                                 |=> spi_start && spi_cmd == CMD_CLR1)
    else $error("second clear command did not follow the first");
  a_mask_code: assert property (spi_start && step_reg == STEP_MASK |-> spi_cmd[7:5] == 3'h1)
    else $error("mask command has wrong upper bits");
  a_mode_locked: assert property (spi_start && step_reg == STEP_MODE |-> spi_cmd[LOCK_BIT])
    else $error("mode command sent without lock bit");
  a_hs_off_ls: assert property (ls_reg != 3'h0 |-> hs_reg == 3'h7 && en_reg)
    else $error("high side on while low sides on");
  a_ls_after_en: assert property ($rose(ls_reg[0]) |-> en_cnt >= EN_LS_CYC)
    else $error("low sides rose too soon after enables");
  a_ls_width: assert property ($fell(ls_reg[0]) |-> ls_cnt >= LS_ON_CYC)
    else $error("low-side charge interval too short");
  a_hs_after_ls: assert property ($fell(hs_reg[0]) |-> ls_reg == 3'h0 && ls_cnt >= LS_ON_CYC)
    else $error("high-side edge without prior low-side toggle");
  a_hs_width: assert property ($rose(hs_reg[0]) |-> hs_cnt >= HS_ON_CYC)
    else $error("high-side re-arm pulse too short");
  a_hs_common: assert property (hs_reg == 3'h0 || hs_reg == 3'h7)
    else $error("high sides not switched together");
  a_irq_service: assert property (state_reg == ST_READY && dirq && !start_req
                                  |=> spi_start && step_reg == STEP_Q0)
    else $error("interrupt not serviced with status query");
  a_resp_next: assert property (state_reg == ST_XFER && spi_done && step_reg == STEP_QD
                                |=> resp1_reg == $past(spi_rx) && resp_ok_reg)
    else $error("second answer not taken from following frame");

  c_init_done: cover property (state_reg == ST_HSON ##1 state_reg == ST_READY);
  c_fault_serviced: cover property (irq_set[IRQ_FAULT] ##[1:1000] irq_set[IRQ_RESP]);
  c_restart: cover property (state_reg == ST_READY && start_req);
endmodule

/* rtl/pds_spi.sv */
/*
  Serial link master: one 8-bit frame per start, MSB first.
  Data changes on the falling clock edge, the device samples on the rising one.
  Assumes the far end drives its answer bit while the link clock is low.
*/
`timescale 1ns/10ps
module pds_spi (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic start_i, // begin a frame
  input wire logic [7:0] data_i, // byte to send
  output logic busy_o, // frame in progress
  output logic done_o, // frame over, one cycle
  output logic [7:0] rx_o, // byte received
  output logic sclk_o, // link clock
  output logic cs_n_o, // chip select, low active
  output logic mosi_o, // data to device
  input wire logic miso_i // data from device
);
  import pds_pkg::*;
  logic [1:0] miso_sync_reg;
  logic [7:0] sh_reg;
  logic [7:0] rx_reg;
  logic [2:0] bit_reg;
  logic [1:0] div_reg;
  logic act_reg;
  logic sclk_reg;
  logic done_reg;

  // pin crosses clock domain: two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_sync_reg <= 2'h0;
    end else begin
      miso_sync_reg <= {miso_sync_reg[0], miso_i};
    end
  end

  // divider and shifter; input sampled at falling time to absorb sync delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      bit_reg <= 3'h0;
      div_reg <= 2'h0;
      act_reg <= 1'b0;
      sclk_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!act_reg) begin
        if (start_i) begin
          act_reg <= 1'b1;
          sh_reg <= data_i;
          bit_reg <= 3'h0;
          div_reg <= 2'h0;
        end
      end else if (div_reg == SPI_HALF) begin
        div_reg <= 2'h0;
        sclk_reg <= !sclk_reg;
        if (sclk_reg) begin
          sh_reg <= {sh_reg[6:0], 1'b0};
          rx_reg <= {rx_reg[6:0], miso_sync_reg[1]};
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            act_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
      end else begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end

  assign busy_o = act_reg;
  assign done_o = done_reg;
  assign rx_o = rx_reg;
  assign sclk_o = sclk_reg;
  assign cs_n_o = !act_reg;
  assign mosi_o = sh_reg[7];
endmodule

/* rtl/pds_timer.sv */
/*
  Down-counter for the sequencer's waits.
  Assumes load is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/10ps
module pds_timer (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic load_i, // start a wait
  input wire logic [11:0] cnt_i, // wait length in cycles
  output logic done_o // wait over
);
  import pds_pkg::*;
  logic [11:0] cnt_reg;

  // a load always restarts, so a stale wait never ends a new one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 12'h000;
    end else if (load_i) begin
      cnt_reg <= cnt_i;
    end else if (cnt_reg != 12'h000) begin
      cnt_reg <= cnt_reg - 12'h001;
    end
  end

  // done reads only the count: the caller's load decode depends on done, so a load term here closes a loop
  assign done_o = (cnt_reg == 12'h000);
endmodule
